// file: verilog/uad_pkg.sv
package uad_pkg;
   // ****************************************
   // Register word offsets (byte address / 4)
   // ****************************************
   localparam logic [3:0] ADDR_FUNC = 4'h0;
   localparam logic [3:0] ADDR_CTRL = 4'h1;
   localparam logic [3:0] ADDR_EVT = 4'h2;
   localparam logic [3:0] ADDR_MASK = 4'h3;
   localparam logic [3:0] ADDR_CNT = 4'h4;
   localparam logic [3:0] ADDR_ERR = 4'h5;
   localparam logic [3:0] ADDR_EP0 = 4'h6;
   localparam logic [3:0] ADDR_ALT = 4'h7;
   // ****************************************
   // Field positions
   // ****************************************
   localparam int FA_EN_BIT = 7;
   localparam int CT_DEN_BIT = 7;
   localparam int CT_IGN_BIT = 6;
   localparam int CT_TGL_BIT = 5;
   localparam int CT_AUTO_DMA_MODE_BIT = 4;
   localparam int CT_TIM_BIT = 3;
   localparam int EV_NEXT_TOGGLE_FLAG_BIT = 5;
   localparam int ER_AEH_BIT = 7;
   localparam int EP0_DEF_BIT = 6;
   // ****************************************
   // Reset values and codes
   // ****************************************
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [2:0] EP_SEL_LAST = 3'h5;
   localparam logic [6:0] DEFAULT_ADDR = 7'h00;
   localparam logic [6:0] FIFO_FULL_LEN = 7'h40;
   localparam logic [3:0] EV_NONE = 4'h0;
endpackage : uad_pkg

// file: verilog/uad_dma_ctrl.sv
// Chosen here: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
module uad_dma_ctrl
   import uad_pkg::*;
(
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic srst_i,
   // Avalon-MM slave
   input wire logic [5:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   // Mode pin
   input wire logic interface_select_pin_i,
   // Token address check from the serial engine
   input wire logic token_valid_i,
   input wire logic [6:0] token_addr_i,
   input wire logic [3:0] token_ep_i,
   output logic token_accept_o,
   // Selected endpoint status from the endpoint logic
   input wire logic tx_done_i,
   input wire logic rx_last_i,
   input wire logic fifo_warn_i,
   input wire logic fifo_empty_i,
   input wire logic tx_last_set_i,
   input wire logic ep_reg_access_i,
   input wire logic fifo_fw_access_i,
   // Packet results from the serial engine
   input wire logic pkt_done_i,
   input wire logic pkt_error_i,
   input wire logic pkt_toggle_i,
   input wire logic [6:0] pkt_len_i,
   // DMA controller handshake
   input wire logic dma_ack_i,
   input wire logic dma_pkt_moved_i,
   output logic dma_req_o,
   // Endpoint steering
   output logic ep_enable_o,
   output logic fifo_flush_o,
   output logic tx_toggle_o,
   output logic tx_toggle_ovr_o,
   output logic dma_summary_o
);
   // ****************************************
   // Types and state
   // ****************************************
   typedef enum logic [1:0] {ST_IDLE, ST_MOVE, ST_WIRE, ST_DRAIN} uad_state_type;
   uad_state_type state_r, state_nxt;
   logic [7:0] func_r, ctrl_r, mask_r, cnt_r, err_r, ep0_r;
   logic [3:0] ev_r;
   logic next_toggle_flag_r, flush_r, req_r, ack_r, tok_r, wait_r;
   logic [6:0] retry_r;
   logic [31:0] rdata_r;

   // Byte-lane write on lane zero
   function automatic logic lane0(input logic [3:0] be);
      return be[0];
   endfunction : lane0

   // ****************************************
   // Bus decode
   // ****************************************
   wire logic [3:0] word_idx = avs_address_i[5:2];
   wire logic mapped = (avs_address_i[1:0] == 2'b00) && (word_idx <= ADDR_ALT);
   wire logic wr_go = avs_write_i && !wait_r && lane0(avs_byteenable_i);
   wire logic wr_func = wr_go && mapped && word_idx == ADDR_FUNC;
   wire logic wr_ctrl = wr_go && mapped && word_idx == ADDR_CTRL;
   wire logic wr_evt = wr_go && mapped && word_idx == ADDR_EVT;
   wire logic wr_mask = wr_go && mapped && word_idx == ADDR_MASK;
   wire logic wr_cnt = wr_go && mapped && word_idx == ADDR_CNT;
   wire logic wr_err = wr_go && mapped && word_idx == ADDR_ERR;
   wire logic wr_ep0 = wr_go && mapped && word_idx == ADDR_EP0;
   wire logic [7:0] wd = avs_writedata_i[7:0];

   // ****************************************
   // Control decode
   // ****************************************
   wire logic dma_master_enable = ctrl_r[CT_DEN_BIT] && !interface_select_pin_i;
   wire logic auto_dma_mode = ctrl_r[CT_AUTO_DMA_MODE_BIT];
   wire logic [2:0] ep_sel = ctrl_r[2:0];
   wire logic sel_ok = ep_sel <= EP_SEL_LAST;
   wire logic sel_tx = !ep_sel[0];
   wire logic auto_error_recovery = err_r[ER_AEH_BIT];
   wire logic auto_on = dma_master_enable && auto_dma_mode;
   wire logic timing_warn = ctrl_r[CT_TIM_BIT] && !auto_dma_mode;
   wire logic auto_dma_mode_rise = wr_ctrl && wd[CT_AUTO_DMA_MODE_BIT] && !auto_dma_mode;
   wire logic den_fall = wr_ctrl && ctrl_r[CT_DEN_BIT] && !wd[CT_DEN_BIT];
   wire logic auto_dma_mode_fall = wr_ctrl && auto_dma_mode && !wd[CT_AUTO_DMA_MODE_BIT] && wd[CT_DEN_BIT];

   // ****************************************
   // Request condition
   // ****************************************
   wire logic tx_cond = timing_warn ? (fifo_warn_i && !tx_done_i)
                                    : (tx_done_i && !tx_last_set_i);
   wire logic rx_cond = (timing_warn ? fifo_warn_i : rx_last_i) && !fifo_empty_i;
   wire logic req_cond = dma_master_enable && sel_ok && (sel_tx ? tx_cond : rx_cond);

   // ****************************************
   // Halts and packet evaluation
   // ****************************************
   wire logic active = state_r != ST_IDLE;
   wire logic hard_halt = den_fall
      || (dma_master_enable && fifo_fw_access_i)
      || (auto_on && ep_reg_access_i);
   wire logic tgl_bad = pkt_toggle_i != next_toggle_flag_r;
   wire logic rx_chk = !(ctrl_r[CT_IGN_BIT] && !sel_tx);
   wire logic pkt_bad = pkt_error_i || (tgl_bad && rx_chk);
   wire logic pkt_ok = pkt_done_i && active && !pkt_bad;
   wire logic pkt_err = pkt_done_i && active && pkt_bad;
   wire logic fault_set = pkt_err && (!auto_error_recovery || retry_r == 7'h00);
   wire logic cnt_done = pkt_ok && cnt_r == RST_BYTE;
   wire logic short_set = pkt_ok && !sel_tx && pkt_len_i < FIFO_FULL_LEN;
   wire logic soft_halt = state_r == ST_DRAIN && !ack_r;
   wire logic [3:0] ev_set = {short_set, cnt_done, fault_set, hard_halt || soft_halt};
   wire logic any_ev = ev_r != EV_NONE;
   wire logic addr_hit = func_r[FA_EN_BIT] && token_addr_i == func_r[6:0];
   wire logic def_hit = func_r[FA_EN_BIT] && ep0_r[EP0_DEF_BIT]
      && token_addr_i == DEFAULT_ADDR && token_ep_i == 4'h0;

   // ****************************************
   // Sequencer next state
   // ****************************************
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         ST_IDLE: begin
            if (auto_on && !any_ev && sel_ok) begin
               state_nxt = sel_tx ? ST_MOVE : ST_WIRE;
            end
         end
         ST_MOVE: begin
            if (dma_pkt_moved_i) begin
               state_nxt = sel_tx ? ST_WIRE : (auto_dma_mode ? ST_WIRE : ST_DRAIN);
            end
         end
         ST_WIRE: begin
            if (pkt_ok) begin
               state_nxt = sel_tx ? (auto_dma_mode ? ST_MOVE : ST_DRAIN) : ST_MOVE;
            end
         end
         ST_DRAIN: begin
            state_nxt = ST_IDLE;
         end
      endcase
      if (hard_halt || any_ev || fault_set || !dma_master_enable) begin
         state_nxt = ST_IDLE;
      end else if (auto_dma_mode_fall && state_r == ST_IDLE) begin
         state_nxt = ST_DRAIN;
      end
   end

   // ****************************************
   // Sequencer and request registers
   // ****************************************
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         state_r <= ST_IDLE;
         req_r <= 1'b0;
         ack_r <= 1'b0;
         flush_r <= 1'b0;
         tok_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         req_r <= auto_dma_mode ? (state_nxt == ST_MOVE) : req_cond;
         ack_r <= dma_ack_i;
         flush_r <= auto_dma_mode_rise;
         tok_r <= token_valid_i && (addr_hit || def_hit);
      end
   end

   // ****************************************
   // Register file
   // ****************************************
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         func_r <= RST_BYTE;
         ctrl_r <= RST_BYTE;
         mask_r <= RST_BYTE;
         err_r <= RST_BYTE;
         ep0_r <= RST_BYTE;
      end else begin
         if (wr_func) func_r <= wd;
         if (wr_mask) mask_r <= {4'h0, wd[3:0]};
         if (wr_err && !auto_on) err_r <= wd;
         if (wr_ep0) ep0_r <= {1'b0, wd[EP0_DEF_BIT], 6'h00};
         if (wr_ctrl) begin
            ctrl_r <= wd;
         end else if (any_ev && auto_dma_mode) begin
            ctrl_r[CT_AUTO_DMA_MODE_BIT] <= 1'b0;
         end
      end
   end

   // ****************************************
   // Events, toggle, counters
   // ****************************************
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         ev_r <= EV_NONE;
         next_toggle_flag_r <= 1'b0;
         cnt_r <= RST_BYTE;
         retry_r <= 7'h00;
      end else begin
         // Set wins over write-one-to-clear
         ev_r <= (ev_r & ~(wr_evt ? wd[3:0] : EV_NONE)) | ev_set;
         if (wr_ctrl) begin
            next_toggle_flag_r <= wd[CT_TGL_BIT];
         end else if (pkt_done_i && !pkt_bad) begin
            // Flips on every good packet of the selected endpoint, auto mode or not, except in a cycle that writes CTRL
            next_toggle_flag_r <= ~next_toggle_flag_r;
         end
         if (wr_cnt) begin
            cnt_r <= wd;
         end else if (pkt_ok && cnt_r != RST_BYTE) begin
            cnt_r <= cnt_r - 8'h01;
         end
         if (!active || pkt_ok || wr_err) begin
            retry_r <= wr_err && !auto_on ? wd[6:0] : err_r[6:0];
         end else if (pkt_err && auto_error_recovery && retry_r != 7'h00) begin
            retry_r <= retry_r - 7'h01;
         end
      end
   end

   // ****************************************
   // Read mux and bus answer
   // ****************************************
   wire logic summary = |(ev_r & mask_r[3:0]);
   wire logic [7:0] ev_rd = {2'b00, next_toggle_flag_r, 1'b0, ev_r};
   wire logic [7:0] err_rd = {err_r[ER_AEH_BIT], active ? retry_r : err_r[6:0]};
   wire logic [7:0] rd_byte =
      !mapped ? RST_BYTE :
      word_idx == ADDR_FUNC ? func_r :
      word_idx == ADDR_CTRL ? ctrl_r :
      word_idx == ADDR_EVT ? ev_rd :
      word_idx == ADDR_MASK ? mask_r :
      word_idx == ADDR_CNT ? cnt_r :
      word_idx == ADDR_ERR ? err_rd :
      word_idx == ADDR_EP0 ? ep0_r : {7'h00, summary};

   // One wait cycle per access
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         wait_r <= 1'b1;
         rdata_r <= 32'h0000_0000;
      end else begin
         wait_r <= !((avs_read_i || avs_write_i) && wait_r);
         if (avs_read_i && wait_r) rdata_r <= {24'h00_0000, rd_byte};
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   logic en_r, tovr_r, sum_r;
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         en_r <= 1'b0;
         tovr_r <= 1'b0;
         sum_r <= 1'b0;
      end else begin
         en_r <= state_nxt == ST_WIRE;
         tovr_r <= auto_dma_mode && sel_tx;
         sum_r <= summary;
      end
   end

   assign avs_readdata_o = rdata_r;
   assign avs_waitrequest_o = wait_r;
   assign token_accept_o = tok_r;
   assign dma_req_o = req_r;
   assign ep_enable_o = en_r;
   assign fifo_flush_o = flush_r;
   assign tx_toggle_o = next_toggle_flag_r;
   assign tx_toggle_ovr_o = tovr_r;
   assign dma_summary_o = sum_r;
endmodule : uad_dma_ctrl
`default_nettype wire

// file: sim/uad_chk.sv
`timescale 1ns/1ps
`default_nettype none
// ****************
// Port checks
// ****************
module uad_chk (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic srst_i,
   // Watched inputs
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic interface_select_pin_i,
   input wire logic token_valid_i,
   input wire logic pkt_done_i,
   // Watched outputs
   input wire logic [31:0] avs_readdata_o,
   input wire logic avs_waitrequest_o,
   input wire logic token_accept_o,
   input wire logic dma_req_o,
   input wire logic fifo_flush_o,
   input wire logic tx_toggle_o
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (srst_i);
   // Bus answers after one wait cycle and returns to its idle level
   wait_answer_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
      |=> !avs_waitrequest_o) else $error("bus answer late");
   wait_idle_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
      else $error("waitrequest stuck low");
   upper_zero_a: assert property (avs_readdata_o[31:8] == '0) else $error("upper bytes set");
   read_stable_a: assert property (!(avs_read_i && avs_waitrequest_o) |=> $stable(avs_readdata_o))
      else $error("read data moved");
   // Token, flush, toggle and serial-mode relations
   token_cause_a: assert property (token_accept_o |-> $past(token_valid_i))
      else $error("accept without token");
   flush_pulse_a: assert property (fifo_flush_o |=> !fifo_flush_o)
      else $error("flush too long");
   toggle_cause_a: assert property ($changed(tx_toggle_o)
      |-> $past(pkt_done_i || (avs_write_i && !avs_waitrequest_o))) else $error("toggle moved");
   serial_block_a: assert property ($rose(dma_req_o) |-> $past(!interface_select_pin_i))
      else $error("request in serial mode");
endmodule : uad_chk
`default_nettype wire

// file: sim/uad_dma_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************
// DMA controller stand-in
// ****************
module uad_dma_model (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic srst_i,
   // Handshake
   input wire logic req_i,
   input wire logic slow_i,
   output logic ack_o,
   output logic moved_o
);
   logic [1:0] st_r;
   logic [2:0] cnt_r;
   // One packet per request, prompt or slow, then a short rest
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         st_r <= 2'h0;
         cnt_r <= 3'h0;
         ack_o <= 1'b0;
         moved_o <= 1'b0;
      end else begin
         moved_o <= 1'b0;
         if (cnt_r != 3'h0) begin
            cnt_r <= cnt_r - 3'h1;
         end else if (st_r == 2'h0 && req_i) begin
            st_r <= 2'h1;
            ack_o <= 1'b1;
            cnt_r <= slow_i ? 3'h6 : 3'h1;
         end else if (st_r == 2'h1) begin
            st_r <= 2'h2;
            ack_o <= 1'b0;
            moved_o <= 1'b1;
         end else begin
            st_r <= 2'h0;
         end
      end
   end
endmodule : uad_dma_model
`default_nettype wire

// file: sim/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
   import uad_pkg::*;
   logic core_clk_i, srst_i, rd_i, wr_i, pin, tok_v, tx_done, rx_last, warn, empty, ep_acc;
   logic fw_acc, pkt_done, pkt_err, pkt_tgl, ack, moved, slow, wait_o, acc_o, req_o, en_o;
   logic flush_o, tgl_o, ovr_o, sum_o, tx_last;
   logic [5:0] addr;
   logic [31:0] wdata, rdata, seed;
   logic [6:0] tok_a, fa, plen;
   logic [3:0] tok_ep;
   logic [7:0] q, cb;
   int fails, comparisons, flushes;
   uad_dma_ctrl dut (.core_clk_i(core_clk_i), .srst_i(srst_i), .avs_address_i(addr),
      .avs_read_i(rd_i), .avs_write_i(wr_i), .avs_writedata_i(wdata), .avs_byteenable_i(4'hf),
      .avs_readdata_o(rdata), .avs_waitrequest_o(wait_o), .interface_select_pin_i(pin),
      .token_valid_i(tok_v), .token_addr_i(tok_a), .token_ep_i(tok_ep), .token_accept_o(acc_o),
      .tx_done_i(tx_done), .rx_last_i(rx_last), .fifo_warn_i(warn), .fifo_empty_i(empty),
      .tx_last_set_i(tx_last), .ep_reg_access_i(ep_acc), .fifo_fw_access_i(fw_acc),
      .pkt_done_i(pkt_done), .pkt_error_i(pkt_err), .pkt_toggle_i(pkt_tgl),
      .pkt_len_i(plen), .dma_ack_i(ack), .dma_pkt_moved_i(moved), .dma_req_o(req_o),
      .ep_enable_o(en_o), .fifo_flush_o(flush_o), .tx_toggle_o(tgl_o),
      .tx_toggle_ovr_o(ovr_o), .dma_summary_o(sum_o));
   uad_dma_model dma (.core_clk_i(core_clk_i), .srst_i(srst_i), .req_i(req_o),
      .slow_i(slow), .ack_o(ack), .moved_o(moved));
   // ****************
   // Helpers
   // ****************
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   task automatic complete_run;
      if (fails == 0 && comparisons > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : complete_run
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("mismatch at %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk_i);
   endtask : cyc
   // One bus transfer, held until waitrequest is seen low
   task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
      int n;
      @(posedge core_clk_i);
      addr <= {a, 2'b00};
      wdata <= {24'h00_0000, d};
      wr_i <= w;
      rd_i <= !w;
      n = 0;
      do begin
         @(posedge core_clk_i);
         n++;
      end while (wait_o !== 1'b0 && n < 40);
      q = rdata[7:0];
      rd_i <= 1'b0;
      wr_i <= 1'b0;
      if (wait_o !== 1'b0) begin
         fails++;
         complete_run();
      end
   endtask : bus
   task automatic rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
      bus(1'b0, a, 8'h00);
      chk(q & m, e);
   endtask : rd
   task automatic tok(input logic [6:0] a, input logic [3:0] e, input logic x);
      @(posedge core_clk_i);
      tok_v <= 1'b1;
      tok_a <= a;
      tok_ep <= e;
      @(posedge core_clk_i);
      tok_v <= 1'b0;
      @(posedge core_clk_i);
      chk(acc_o, x);
   endtask : tok
   task automatic wait_en;
      int n;
      for (n = 0; n < 60 && en_o !== 1'b1; n++) @(posedge core_clk_i);
      if (en_o !== 1'b1) begin
         fails++;
         complete_run();
      end
   endtask : wait_en
   task automatic packet(input logic e, input logic t);
      @(posedge core_clk_i);
      pkt_done <= 1'b1;
      pkt_err <= e;
      pkt_tgl <= t;
      @(posedge core_clk_i);
      pkt_done <= 1'b0;
      cyc(2);
   endtask : packet
   // Clock, flush counter and hang guard
   initial begin
      core_clk_i = 1'b0;
      forever #2 core_clk_i = ~core_clk_i;
   end
   always @(posedge core_clk_i) if (flush_o === 1'b1) flushes++;
   initial begin
      cyc(20000);
      fails++;
      complete_run();
   end
   // ****************
   // Main sequence
   // ****************
   initial begin
      {srst_i, rd_i, wr_i, pin, tok_v, tx_done, rx_last, warn, empty, ep_acc} = 10'h200;
      {fw_acc, pkt_done, pkt_err, pkt_tgl, slow, tx_last, addr, wdata, tok_a, tok_ep} = '0;
      plen = FIFO_FULL_LEN;
      srst_i = 1'b1;
      seed = 32'h0001_7182;
      cyc(4);
      srst_i <= 1'b0;
      for (int a = 0; a < 3; a++) rd(a[3:0], 8'hff, RST_BYTE);
      bus(1'b1, 4'h8, 8'h5a);
      rd(4'h8, 8'hff, 8'h00);
      for (int i = 0; i < 4; i++) begin
         seed = lfsr(seed);
         fa = seed[6:0] | 7'h01;
         bus(1'b1, ADDR_FUNC, {1'b1, fa});
         rd(ADDR_FUNC, 8'hff, {1'b1, fa});
         tok(fa, seed[11:8], 1'b1);
         tok(fa ^ 7'h02, 4'h1, 1'b0);
      end
      tok(DEFAULT_ADDR, 4'h0, 1'b0);
      bus(1'b1, ADDR_EP0, 8'h40);
      tok(DEFAULT_ADDR, 4'h0, 1'b1);
      tok(DEFAULT_ADDR, 4'h1, 1'b0);
      bus(1'b1, ADDR_FUNC, {1'b0, fa});
      tok(fa, 4'h1, 1'b0);
      for (int c = 0; c < 6; c++) begin
         bus(1'b1, ADDR_CTRL, 8'h80 | c[7:0]);
         if (c[0]) rx_last <= 1'b1;
         else tx_done <= 1'b1;
         cyc(2);
         chk(req_o, 1'b1);
         {tx_done, rx_last} <= 2'b00;
         cyc(2);
         chk(req_o, 1'b0);
      end
      rx_last <= 1'b1;
      cyc(2);
      empty <= 1'b1;
      cyc(2);
      chk(req_o, 1'b0);
      {rx_last, empty} <= 2'b00;
      // Final command pending keeps a completed transmit from requesting
      bus(1'b1, ADDR_CTRL, 8'h80);
      {tx_done, tx_last} <= 2'b11;
      cyc(2);
      chk(req_o, 1'b0);
      {tx_done, tx_last} <= 2'b00;
      bus(1'b1, ADDR_CTRL, 8'h88);
      warn <= 1'b1;
      cyc(2);
      chk(req_o, 1'b1);
      warn <= 1'b0;
      cyc(2);
      chk(req_o, 1'b0);
      pin <= 1'b1;
      bus(1'b1, ADDR_CTRL, 8'h00);
      bus(1'b1, ADDR_CTRL, 8'h80);
      tx_done <= 1'b1;
      cyc(2);
      chk(req_o, 1'b0);
      {pin, tx_done} <= 2'b00;
      bus(1'b1, ADDR_CTRL, 8'h20);
      rd(ADDR_EVT, 8'h20, 8'h20);
      packet(1'b0, 1'b1);
      chk(tgl_o, 1'b0);
      bus(1'b1, ADDR_CTRL, 8'h00);
      // Automatic transmit of two packets with a countdown of one
      bus(1'b1, ADDR_EVT, 8'h0f);
      bus(1'b1, ADDR_CNT, 8'h01);
      bus(1'b1, ADDR_CTRL, 8'h10);
      bus(1'b1, ADDR_CTRL, 8'h90);
      wait_en();
      chk(ovr_o, 1'b1);
      packet(1'b0, 1'b0);
      rd(ADDR_CNT, 8'hff, 8'h00);
      chk(tgl_o, 1'b1);
      slow <= seed[0];
      wait_en();
      packet(1'b0, 1'b1);
      rd(ADDR_EVT, 8'h0f, 8'h04);
      rd(ADDR_CTRL, 8'h10, 8'h00);
      chk(flushes != 0, 1'b1);
      bus(1'b1, ADDR_MASK, 8'h04);
      cyc(2);
      chk(sum_o, 1'b1);
      bus(1'b1, ADDR_MASK, 8'h0b);
      cyc(2);
      chk(sum_o, 1'b0);
      // Halts by register access, FIFO access, enable clear, a faulty packet,
      // short receive packets with and without toggle check, and auto clear
      for (int k = 0; k < 7; k++) begin
         cb = (k == 4) ? 8'h11 : (k == 5) ? 8'h51 : 8'h10;
         bus(1'b1, ADDR_CTRL, 8'h00);
         bus(1'b1, ADDR_EVT, 8'h0f);
         bus(1'b1, ADDR_CTRL, cb);
         bus(1'b1, ADDR_CTRL, cb | 8'h80);
         cyc(3);
         if (k == 0) ep_acc <= 1'b1;
         if (k == 1) fw_acc <= 1'b1;
         if (k == 2) bus(1'b1, ADDR_CTRL, 8'h10);
         if (k == 6) bus(1'b1, ADDR_CTRL, 8'h80);
         plen <= (k >= 4) ? 7'h05 : FIFO_FULL_LEN;
         if (k >= 3) wait_en();
         if (k >= 3) packet(k == 3, (k == 5) ^ tgl_o);
         @(posedge core_clk_i);
         {ep_acc, fw_acc} <= 2'b00;
         cyc(3);
         cb = (k == 3) ? 8'h02 : (k == 6) ? 8'h05 : (k >= 4) ? 8'h0c : 8'h01;
         rd(ADDR_EVT, 8'h0f, cb);
      end
      complete_run();
   end
endmodule : tb
bind uad_dma_ctrl uad_chk chk_i (.core_clk_i(core_clk_i), .srst_i(srst_i),
   .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
   .interface_select_pin_i(interface_select_pin_i), .token_valid_i(token_valid_i),
   .pkt_done_i(pkt_done_i), .avs_readdata_o(avs_readdata_o),
   .avs_waitrequest_o(avs_waitrequest_o), .token_accept_o(token_accept_o),
   .dma_req_o(dma_req_o), .fifo_flush_o(fifo_flush_o), .tx_toggle_o(tx_toggle_o));
`default_nettype wire
